// ### common/tlt_consts.svh
`ifndef TLT_CONSTS_SVH
`define TLT_CONSTS_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define TLT_ADDR_CTRL 8'h00
`define TLT_ADDR_STATUS 8'h04
`define TLT_ADDR_IRQ_STAT 8'h08
`define TLT_ADDR_IRQ_MASK 8'h0C
`define TLT_ADDR_ERR_COUNT 8'h10

// ----------------------------------------
// field positions
// ----------------------------------------
`define TLT_CTRL_START 0
`define TLT_CTRL_STOP 1
`define TLT_CTRL_INJECT 2
`define TLT_CTRL_CLEAR 3
`define TLT_IRQ_ERROR 0
`define TLT_IRQ_STARTED 1
`define TLT_IRQ_STOPPED 2
`define TLT_IRQ_W 3
`define TLT_IRQ_MASK_RESET 3'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define TLT_CLK_HZ 10000000
`define TLT_TICK_US 1000
`define TLT_TICK_CYCLES ((`TLT_CLK_HZ / 1000000) * `TLT_TICK_US)
`define TLT_DEBOUNCE_TICKS 10
`define TLT_COUNT_MAX 8'h99

`endif

// ### common/tlt_pkg.sv
package tlt_pkg;

    // dipswitch 6 then dipswitch 5, 1 = up
    typedef enum logic [1:0] {
        PATH_SFP = 2'b00,
        PATH_MODULE = 2'b01,
        PATH_COAX = 2'b10,
        PATH_BACKPLANE = 2'b11
    } path_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } run_state_t;

    typedef struct packed {
        logic sync;
        logic align;
        logic data_valid;
    } module_status_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic inject;
        logic clear;
    } command_t;

endpackage

// ### core/button_conditioner.sv
`timescale 1ns/10ps
`include "tlt_consts.svh"

module button_conditioner #(
    parameter int TICKS = `TLT_DEBOUNCE_TICKS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // debounce rate
    input wire logic tick,
    // raw pin, low while pressed
    input wire logic button_b,
    // one pulse per press
    output logic press
);

    if (TICKS < 1 || TICKS > 255) begin : g_bad_ticks
        $error("button_conditioner: TICKS out of range");
    end

    logic meta;
    logic level;
    logic stable;
    logic stable_d;
    logic [7:0] same_count;

    // ----------------------------------------
    // synchroniser
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            meta <= 1'b0;
            level <= 1'b0;
        end else begin
            meta <= ~button_b;
            level <= meta;
        end
    end

    // ----------------------------------------
    // debounce: level must hold for TICKS ticks
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            stable <= 1'b0;
            same_count <= 8'h00;
        end else if (level == stable) begin
            same_count <= 8'h00;
        end else if (tick) begin
            if (same_count == 8'(TICKS - 1)) begin
                stable <= level;
                same_count <= 8'h00;
            end else begin
                same_count <= same_count + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            stable_d <= 1'b0;
        end else begin
            stable_d <= stable;
        end
    end

    assign press = stable & ~stable_d;

endmodule // button_conditioner

// ### core/lane_checker.sv
`timescale 1ns/10ps

module lane_checker #(
    parameter int WORD_W = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // control
    input wire logic clear,
    input wire logic enable,
    input wire logic inject,
    // transmit side
    output logic [WORD_W-1:0] tx_word,
    output logic tx_valid,
    // receive side
    input wire logic [WORD_W-1:0] rx_word,
    input wire logic rx_valid,
    // result
    output logic match,
    output logic mismatch
);

    if (WORD_W < 2) begin : g_bad_width
        $error("lane_checker: WORD_W too small");
    end

    logic [WORD_W-1:0] tx_count;
    logic [WORD_W-1:0] expect_word;
    logic locked;

    // ----------------------------------------
    // generator: incrementing count pattern
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b || clear) begin
            tx_count <= '0;
            tx_word <= '0;
            tx_valid <= 1'b0;
        end else begin
            tx_valid <= enable;
            if (enable) begin
                tx_count <= tx_count + 1'b1;
                // one word with its low bit flipped
                tx_word <= inject ? (tx_count ^ WORD_W'(1)) : tx_count;
            end
        end
    end

    // ----------------------------------------
    // checker: seeded by the first word, then runs
    // on its own so one bad word counts once
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b || clear) begin
            locked <= 1'b0;
            expect_word <= '0;
            match <= 1'b0;
            mismatch <= 1'b0;
        end else begin
            mismatch <= 1'b0;
            if (rx_valid) begin
                expect_word <= (locked ? expect_word : rx_word) + 1'b1;
                locked <= 1'b1;
                if (locked && rx_word != expect_word) begin
                    mismatch <= 1'b1;
                    match <= 1'b0;
                end else begin
                    match <= 1'b1;
                end
            end
        end
    end

endmodule // lane_checker

// ### core/transceiver_loopback_tester.sv
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/10ps
`include "tlt_consts.svh"

// Contract
// - switch 6 up, 5 down: traffic goes over the coaxial connectors
// - switches 6 and 5 up: traffic goes over the backplane connector
// - switches 6 and 5 down: traffic goes over the SFP cages
// - switch 6 down, 5 up: traffic goes over the ten-gigabit module
// - design reset initialises everything and lights the reset LED
// - start begins transmitting; LED 4 lit while running
// - coax and backplane: LEDs 0 to 3 show per-channel match
// - LED 5 lights on any mismatch or injected error
// - stop ends transmission on all channels
// - each inject press corrupts one word; first error shows 01
// - error count accumulates on the two-digit display
// - SFP mode: only the channel with a fitted module shows match
// - module mode: LEDs show match, sync, alignment, data valid
// - repeated start then reset restarts cleanly
module transceiver_loopback_tester
    import tlt_pkg::*;
#(
    parameter int LANES = 4,
    parameter int WORD_W = 16,
    parameter int TICK_CYCLES = `TLT_TICK_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // pushbuttons, low while pressed
    input wire logic test_clear_button_b,
    input wire logic start_button_b,
    input wire logic stop_button_b,
    input wire logic error_inject_button_b,
    // dipswitches 6 and 5, high when up
    input wire logic dip6,
    input wire logic dip5,
    // ten-gigabit module status pins
    input wire module_status_t module_status,
    // transceiver parallel side
    output logic [LANES*WORD_W-1:0] tx_data,
    output logic [LANES-1:0] tx_valid,
    input wire logic [LANES*WORD_W-1:0] rx_data,
    input wire logic [LANES-1:0] rx_valid,
    output path_t transceiver_path_select,
    // indicators
    output logic [5:0] led,
    output logic reset_led,
    output logic [6:0] seg_tens,
    output logic [6:0] seg_ones,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // interrupt
    output logic irq
);

    if (LANES < 1 || LANES > 4) begin : g_bad_lanes
        $error("tester: LANES must be 1 to 4");
    end
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
        $error("tester: TICK_CYCLES out of range");
    end

    // seven-segment pattern, segments g..a, high = lit
    function automatic logic [6:0] seg_decode(input logic [3:0] digit);
        case (digit)
            4'h0: seg_decode = 7'h3F;
            4'h1: seg_decode = 7'h06;
            4'h2: seg_decode = 7'h5B;
            4'h3: seg_decode = 7'h4F;
            4'h4: seg_decode = 7'h66;
            4'h5: seg_decode = 7'h6D;
            4'h6: seg_decode = 7'h7D;
            4'h7: seg_decode = 7'h07;
            4'h8: seg_decode = 7'h7F;
            4'h9: seg_decode = 7'h6F;
            default: seg_decode = 7'h00;
        endcase
    endfunction

    // ----------------------------------------
    // pin synchronisers and debounce rate
    // ----------------------------------------
    logic [1:0] dip_meta;
    logic [1:0] dip_sync;
    logic [2:0] mod_meta;
    module_status_t mod_sync;
    logic [15:0] tick_count;
    logic tick;

    // no reset: the path register latches the switches during reset
    always_ff @(posedge clk_sys) begin
        dip_meta <= {dip6, dip5};
        dip_sync <= dip_meta;
        mod_meta <= module_status;
        mod_sync <= mod_meta;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            tick_count <= 16'h0000;
            tick <= 1'b0;
        end else begin
            tick <= (tick_count == 16'(TICK_CYCLES - 1));
            if (tick_count == 16'(TICK_CYCLES - 1)) begin
                tick_count <= 16'h0000;
            end else begin
                tick_count <= tick_count + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // pushbuttons
    // ----------------------------------------
    command_t button_cmd;
    command_t soft_cmd;
    command_t cmd;

    button_conditioner u_clear_btn (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .tick(tick),
        .button_b(test_clear_button_b),
        .press(button_cmd.clear)
    );
    button_conditioner u_start_btn (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .tick(tick),
        .button_b(start_button_b),
        .press(button_cmd.start)
    );
    button_conditioner u_stop_btn (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .tick(tick),
        .button_b(stop_button_b),
        .press(button_cmd.stop)
    );
    button_conditioner u_inject_btn (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .tick(tick),
        .button_b(error_inject_button_b),
        .press(button_cmd.inject)
    );

    assign cmd = button_cmd | soft_cmd;

    // ----------------------------------------
    // path selection
    // ----------------------------------------
    // switches only take effect on a reset or a clear, so the path cannot
    // change under a running test
    always_ff @(posedge clk_sys) begin
        if (!rst_b || cmd.clear) begin
            transceiver_path_select <= path_t'(dip_sync);
        end
    end

    // ----------------------------------------
    // run control
    // ----------------------------------------
    run_state_t state;
    logic running;

    always_ff @(posedge clk_sys) begin
        if (!rst_b || cmd.clear) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (cmd.start) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (cmd.stop) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    assign running = (state == ST_RUN);

    // ----------------------------------------
    // lanes
    // ----------------------------------------
    logic [LANES-1:0] lane_match;
    logic [LANES-1:0] lane_mismatch;
    logic [LANES-1:0] lane_inject;
    logic [1:0] inject_lane;

    // corrupt the lowest matching lane so the error is seen
    // even with only one cage fitted
    always_comb begin
        inject_lane = 2'd0;
        for (int i = LANES - 1; i >= 0; i--) begin
            if (lane_match[i]) begin
                inject_lane = 2'(i);
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : gen_lane
            assign lane_inject[g] = cmd.inject && inject_lane == 2'(g);

            lane_checker #(
                .WORD_W(WORD_W)
            ) u_lane (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .clear(cmd.clear),
                .enable(running),
                .inject(lane_inject[g]),
                .tx_word(tx_data[g*WORD_W +: WORD_W]),
                .tx_valid(tx_valid[g]),
                .rx_word(rx_data[g*WORD_W +: WORD_W]),
                .rx_valid(rx_valid[g]),
                .match(lane_match[g]),
                .mismatch(lane_mismatch[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // error count, two bcd digits
    // ----------------------------------------
    logic [7:0] err_count;
    logic err_seen;
    logic err_event;

    assign err_event = |lane_mismatch;

    always_ff @(posedge clk_sys) begin
        if (!rst_b || cmd.clear) begin
            err_count <= 8'h00;
        end else if (err_event && err_count != `TLT_COUNT_MAX) begin
            if (err_count[3:0] == 4'h9) begin
                err_count <= {err_count[7:4] + 4'h1, 4'h0};
            end else begin
                err_count <= err_count + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b || cmd.clear) begin
            err_seen <= 1'b0;
        end else if (err_event) begin
            err_seen <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b || cmd.clear) begin
            seg_tens <= seg_decode(4'h0);
            seg_ones <= seg_decode(4'h0);
        end else begin
            seg_tens <= seg_decode(err_count[7:4]);
            seg_ones <= seg_decode(err_count[3:0]);
        end
    end

    // ----------------------------------------
    // indicators
    // ----------------------------------------
    logic [3:0] match_pad;

    assign match_pad = 4'(lane_match);

    always_ff @(posedge clk_sys) begin
        if (!rst_b || cmd.clear) begin
            led <= 6'h00;
        end else begin
            led[4] <= running;
            led[5] <= err_seen;
            if (transceiver_path_select == PATH_MODULE) begin
                led[0] <= match_pad[0];
                led[1] <= mod_sync.sync;
                led[2] <= mod_sync.align;
                led[3] <= mod_sync.data_valid;
            end else begin
                led[3:0] <= match_pad;
            end
        end
    end

    // held from reset until the next start, so a brief press is visible
    always_ff @(posedge clk_sys) begin
        if (!rst_b || cmd.clear) begin
            reset_led <= 1'b1;
        end else if (cmd.start) begin
            reset_led <= 1'b0;
        end
    end

    // ----------------------------------------
    // ahb-lite slave, zero wait states
    // ----------------------------------------
    logic addr_ok;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic rd_clear;
    logic [`TLT_IRQ_W-1:0] irq_stat;
    logic [`TLT_IRQ_W-1:0] irq_mask;
    logic [`TLT_IRQ_W-1:0] irq_event;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_ok = hsel && hready && htrans[1];

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_ok && hwrite;
            wr_addr <= haddr;
        end
    end

    // commands from a ctrl write last one cycle
    always_comb begin
        soft_cmd = '0;
        if (wr_pend && wr_addr == `TLT_ADDR_CTRL) begin
            soft_cmd.start = hwdata[`TLT_CTRL_START];
            soft_cmd.stop = hwdata[`TLT_CTRL_STOP];
            soft_cmd.inject = hwdata[`TLT_CTRL_INJECT];
            soft_cmd.clear = hwdata[`TLT_CTRL_CLEAR];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irq_mask <= `TLT_IRQ_MASK_RESET;
        end else if (wr_pend && wr_addr == `TLT_ADDR_IRQ_MASK) begin
            irq_mask <= hwdata[`TLT_IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            case (haddr)
                `TLT_ADDR_STATUS:
                    hrdata <= {22'h00_0000, transceiver_path_select, err_seen,
                        running, match_pad, 2'b00};
                `TLT_ADDR_IRQ_STAT: hrdata <= {29'h0000_0000, irq_stat};
                `TLT_ADDR_IRQ_MASK: hrdata <= {29'h0000_0000, irq_mask};
                `TLT_ADDR_ERR_COUNT: hrdata <= {24'h00_0000, err_count};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // interrupts: sticky, cleared by reading, set wins
    // ----------------------------------------
    assign rd_clear = addr_ok && !hwrite && haddr == `TLT_ADDR_IRQ_STAT;
    assign irq_event = {running && cmd.stop, !running && cmd.start, err_event};

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (rd_clear ? '0 : irq_stat) | irq_event;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((rd_clear ? '0 : irq_stat) | irq_event) & irq_mask);
        end
    end

endmodule // transceiver_loopback_tester

// ### tb/loopback_cables.sv
`timescale 1ns/10ps

module loopback_cables #(
    parameter int LANES = 4,
    parameter int WORD_W = 16
) (
    // clock
    input wire logic clk_sys,
    // one bit per lane with a cable or module in place
    input wire logic [LANES-1:0] fitted,
    // device side
    input wire logic [LANES*WORD_W-1:0] tx_data,
    input wire logic [LANES-1:0] tx_valid,
    output logic [LANES*WORD_W-1:0] rx_data,
    output logic [LANES-1:0] rx_valid
);
    logic [LANES*WORD_W-1:0] cable_data;
    logic [LANES-1:0] cable_valid;

    always_ff @(posedge clk_sys) begin
        cable_data <= tx_data;
        cable_valid <= tx_valid;
    end

    // empty cage returns nothing valid; garbage so no stale word passes
    always_ff @(posedge clk_sys) begin
        for (int g = 0; g < LANES; g++) begin
            rx_valid[g] <= cable_valid[g] & fitted[g];
            rx_data[g*WORD_W+:WORD_W] <= (cable_valid[g] & fitted[g]) ?
                cable_data[g*WORD_W+:WORD_W] : ~cable_data[g*WORD_W+:WORD_W];
        end
    end
endmodule // loopback_cables

// ### tb/test_transceiver_loopback_tester.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_errors++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end

module test_transceiver_loopback_tester;
    import tlt_pkg::*;

    // ----
    // signals
    // ----
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] btn_b = 4'hf; // start, stop, inject, clear
    logic dip6 = 1'b1;
    logic dip5 = 1'b0;
    module_status_t module_status = 3'b101;
    logic [63:0] tx_data;
    logic [63:0] rx_data;
    logic [3:0] tx_valid;
    logic [3:0] rx_valid;
    logic [3:0] fitted = 4'hf;
    path_t path;
    logic [5:0] led;
    logic reset_led;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic [6:0] seg_tens;
    logic [6:0] seg_ones;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic [31:0] q;
    logic [5:0] exp_led [4] = '{6'h11, 6'h1b, 6'h1f, 6'h1f};
    int n_errors = 0;
    int num_checks = 0;

    always #50 clk_sys = ~clk_sys;

    transceiver_loopback_tester #(.TICK_CYCLES(2)) dut (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .test_clear_button_b(btn_b[3]),
        .start_button_b(btn_b[0]),
        .stop_button_b(btn_b[1]),
        .error_inject_button_b(btn_b[2]),
        .dip6(dip6),
        .dip5(dip5),
        .module_status(module_status),
        .tx_data(tx_data),
        .tx_valid(tx_valid),
        .rx_data(rx_data),
        .rx_valid(rx_valid),
        .transceiver_path_select(path),
        .led(led),
        .reset_led(reset_led),
        .seg_tens(seg_tens),
        .seg_ones(seg_ones),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .irq(irq)
    );

    loopback_cables cables (
        .clk_sys(clk_sys),
        .fitted(fitted),
        .tx_data(tx_data),
        .tx_valid(tx_valid),
        .rx_data(rx_data),
        .rx_valid(rx_valid)
    );

    // ----
    // tasks
    // ----
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        bus(1'b0, a, 32'h0000_0000);
        `CHK("register", ex, q)
        `CHK("hresp", 1'b0, hresp)
    endtask

    // long enough for sync plus ten debounce ticks on press and release
    task automatic press(input int b);
        @(posedge clk_sys);
        btn_b[b] <= 1'b0;
        repeat (40) @(posedge clk_sys);
        btn_b[b] <= 1'b1;
        repeat (40) @(posedge clk_sys);
    endtask

    task automatic hw_reset;
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic end_sim;
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----
    // tests
    // ----
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        `CHK("path", PATH_COAX, path)
        `CHK("reset led", 1'b1, reset_led)
        `CHK("display", 14'h1fbf, {seg_tens, seg_ones})
        bus(1'b1, 8'h0c, 32'h0000_0001);
        rd(8'h0c, 32'h0000_0001);
        press(0);
        `CHK("leds", 6'h1f, led)
        `CHK("reset led", 1'b0, reset_led)
        `CHK("tx valid", 4'hf, tx_valid)
        `CHK("irq", 1'b0, irq)
        rd(8'h08, 32'h0000_0002);
        rd(8'h08, 32'h0000_0000);
        press(2);
        `CHK("display", 14'h1f86, {seg_tens, seg_ones})
        `CHK("irq", 1'b1, irq)
        rd(8'h08, 32'h0000_0001);
        repeat (2) @(posedge clk_sys);
        `CHK("irq", 1'b0, irq)
        press(2);
        press(2);
        `CHK("display", 14'h1fcf, {seg_tens, seg_ones})
        rd(8'h10, 32'h0000_0003);
        rd(8'h04, 32'h0000_02fc);
        bus(1'b1, 8'h04, 32'h0000_0000);
        rd(8'h04, 32'h0000_02fc);
        rd(8'h20, 32'h0000_0000);
        press(1);
        `CHK("tx valid", 4'h0, tx_valid)
        `CHK("run led", 1'b0, led[4])
        rd(8'h08, 32'h0000_0005);
        press(3);
        `CHK("display", 14'h1fbf, {seg_tens, seg_ones})
        `CHK("leds", 6'h00, led)
        for (int p = 0; p < 4; p++) begin
            dip6 <= p[1];
            dip5 <= p[0];
            fitted <= (p == 0) ? 4'b0001 : 4'hf;
            hw_reset;
            `CHK("path", path_t'(p[1:0]), path)
            press(0);
            `CHK("leds", exp_led[p], led)
        end
        bus(1'b1, 8'h00, 32'h0000_0004);
        repeat (4) @(posedge clk_sys);
        rd(8'h10, 32'h0000_0001);
        bus(1'b1, 8'h00, 32'h0000_0002);
        repeat (2) @(posedge clk_sys);
        `CHK("tx valid", 4'h0, tx_valid)
        bus(1'b1, 8'h00, 32'h0000_0008);
        rd(8'h10, 32'h0000_0000);
        bus(1'b1, 8'h00, 32'h0000_0001);
        repeat (2) @(posedge clk_sys);
        `CHK("run led", 1'b1, led[4])
        end_sim;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        end_sim;
    end
endmodule // test_transceiver_loopback_tester

// ### tb/tlt_checker.sv
`timescale 1ns/10ps

module tlt_checker
    import tlt_pkg::*;
#(
    parameter int LANES = 4,
    parameter int WORD_W = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // lanes and indicators
    input wire logic [LANES*WORD_W-1:0] tx_data,
    input wire logic [LANES-1:0] tx_valid,
    input wire path_t transceiver_path_select,
    input wire logic [5:0] led,
    input wire logic reset_led,
    input wire logic [6:0] seg_ones
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_reset_state: assert property (
        $rose(rst_b) |-> led == 6'h00 && reset_led && seg_ones == 7'h3f && tx_valid == '0)
        else $error("state not cleared by reset");
    a_start_tx_on: assert property (
        $rose(led[4]) |-> ##[0:3] |tx_valid)
        else $error("running without transmission");
    a_stop_tx_off: assert property (
        $fell(led[4]) |-> ##[0:3] tx_valid == '0)
        else $error("transmission goes on after stop");
    a_start_rled_off: assert property (
        $rose(led[4]) |=> !reset_led)
        else $error("reset led lit while running");
    a_count_err_led: assert property (
        $changed(seg_ones) && seg_ones != 7'h3f |-> led[5])
        else $error("count shown without error led");
    // lane 2 is never the injected lane while lane 0 matches
    a_pattern_steps: assert property (
        tx_valid[2] && $past(tx_valid[2]) |-> tx_data[47:32] == $past(tx_data[47:32]) + 16'h0001)
        else $error("lane pattern does not step");
    a_path_static: assert property (
        $changed(transceiver_path_select) |-> reset_led)
        else $error("path changed outside reset or clear");
    a_rdata_hold: assert property (
        $changed(hrdata) |-> $past(hsel) && $past(hready) &&
            $past(htrans[1]) && !$past(hwrite))
        else $error("read data changed without a read");
endmodule // tlt_checker

bind transceiver_loopback_tester tlt_checker #(.LANES(LANES), .WORD_W(WORD_W)) chk (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .hsel(hsel),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hrdata(hrdata),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .transceiver_path_select(transceiver_path_select),
    .led(led),
    .reset_led(reset_led),
    .seg_ones(seg_ones)
);
